/* File: lwle_pkg.sv */
// constants, register map and state type of the lan wake, indicator and error sideband
package lwle_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_POWER_CTL_STATUS_REG = 8'h04;
  localparam logic [7:0] ADDR_WUC = 8'h08;
  localparam logic [7:0] ADDR_WAKE_FILTER_CONTROL_REG = 8'h0c;
  localparam logic [7:0] ADDR_WUS = 8'h10;
  localparam logic [7:0] ADDR_IND = 8'h14;
  localparam logic [7:0] ADDR_LINK = 8'h18;
  // field positions
  localparam int CFG_PERR_EN = 0;
  localparam int CFG_SERR_EN = 1;
  localparam int CFG_PERR_FLAG = 8;
  localparam int CFG_SERR_FLAG = 9;
  localparam int PM_EN = 8;
  localparam int PM_FLAG = 15;
  localparam int WUC_MAGIC = 0;
  localparam int WAKE_FILTER_CONTROL_REG_LNK = 0;
  localparam int WAKE_FILTER_CONTROL_REG_FILT_LSB = 1;
  localparam int WUS_LNK = 0;
  localparam int WUS_MAGIC = 1;
  localparam int WUS_FILT_LSB = 2;
  localparam int IND_BLINK_FAST = 24;
  localparam int IND_W = 8;
  localparam int IND_INV = 5;
  localparam int IND_BLINK = 7;
  localparam int NUM_IND = 3;
  localparam int NUM_FILT = 8;
  // synchronised phy status vector
  localparam int PS_LINK = 0;
  localparam int PS_SPD = 1;
  localparam int PS_DUPLEX = 3;
  localparam int PS_ACT = 4;
  localparam int PS_COL = 5;
  localparam int PS_PAUSE = 6;
  localparam int PS_LEGACY = 7;
  localparam int PS_W = 8;
  // codes and reset values
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_D3 = 2'h3;
  localparam logic [2:0] CPL_SUCCESS = 3'h0;
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [23:0] IND_RST = 24'h000302;
  localparam logic [3:0] SRC_LINK_100_1000 = 4'h0;
  localparam logic [3:0] SRC_LINK_10_1000 = 4'h1;
  localparam logic [3:0] SRC_LINK_UP = 4'h2;
  localparam logic [3:0] SRC_ACTIVITY = 4'h3;
  localparam logic [3:0] SRC_LINK_IDLE = 4'h4;
  localparam logic [3:0] SRC_LINK_10 = 4'h5;
  localparam logic [3:0] SRC_LINK_100 = 4'h6;
  localparam logic [3:0] SRC_LINK_1000 = 4'h7;
  localparam logic [3:0] SRC_FULL_DUPLEX = 4'h8;
  localparam logic [3:0] SRC_COLLISION = 4'h9;
  localparam logic [3:0] SRC_TX_THROTTLED = 4'ha;
  localparam logic [3:0] SRC_CONST_ON = 4'he;
  localparam logic [3:0] SRC_CONST_OFF = 4'hf;
  // blink timing
  localparam int CLK_KHZ = 40000;
  localparam int BLINK_SLOW_MS = 200;
  localparam int BLINK_FAST_MS = 83;
  localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_KHZ;
  localparam int BLINK_FAST_CYC = BLINK_FAST_MS * CLK_KHZ;
  localparam int CNT_W = 24;

  typedef struct packed {
    logic perr_report_en;
    logic serr_en;
    logic parity_flag;
    logic serr_flag;
    logic [1:0] pstate;
    logic power_event_enable;
    logic pme_flag;
    logic magic_en;
    logic [NUM_FILT-1:0] filt_sel;
    logic lnk_wake_en;
    logic wus_link;
    logic wus_magic;
    logic [NUM_FILT-1:0] wus_filt;
    logic [NUM_IND*IND_W-1:0] ind_cfg;
    logic blink_fast;
    logic [CNT_W-1:0] blink_cnt;
    logic blink_phase;
    logic wake_pend;
    logic wake_req;
    logic link_prev;
    logic [PS_W-1:0] phy_s1;
    logic [PS_W-1:0] phy_s2;
    logic [31:0] rdata;
    logic sys_err;
    logic rx_deliver;
    logic [NUM_IND-1:0] ind_out;
  } lwle_state_t;
endpackage : lwle_pkg

/* File: lwle_top.sv */
// lan sideband: host bus errors, power state, wake logic and link indicators
// Operation
// - host bus parity error sets parity flag and drops the cycle
// - parity error raises system error when parity reporting enabled
// - non-success completion dropped, never retried, sets system error flag
// - 1000 full duplex only; legacy mode uses narrow link only
// - outside D0 only configuration requests are accepted
// - wake packet withheld; power event flag set before wake request
// - nvm load copies magic wake enable into wake control
// - magic packet sets magic status, power event flag, wake request
// - magic wake in all power states; off by nvm or software
// - filtered wake needs address filter pass plus one selected filter
// - filtered match sets flag; wake only with power event enable
// - every matching filter sets its own received bit
// - enabled link up/down sets flag, link bit, wake request
// - wake held until flag write-one or enable write-zero
// - packets ignored while received bits set; links while link bit
// - writing 11 to low power bits enters D3
// - three indicators, each with own source, polarity, blink
// - speed sources 100/1000, 10/1000, any link, exact speed
// - activity, idle, duplex, collision, throttled, constant on, off
// - invert applied before blink logic
// - blink toggles at 200 ms or 83 ms, one shared rate
// - indicator defaults load from nvm, software may override
`timescale 1ns/1ps
`default_nettype none
module lwle_top #(
  parameter logic [23:0] BLINK_SLOW_CYC = 24'(lwle_pkg::BLINK_SLOW_CYC),
  parameter logic [23:0] BLINK_FAST_CYC = 24'(lwle_pkg::BLINK_FAST_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic hb_req_valid_i,
  input wire logic hb_req_is_cfg_i,
  input wire logic hb_parity_err_i,
  output logic hb_req_accept_o,
  output logic hb_req_drop_o,
  input wire logic cpl_valid_i,
  input wire logic [2:0] cpl_status_i,
  output logic cpl_accept_o,
  output logic cpl_drop_o,
  output logic system_error_o,
  input wire logic nvm_load_i,
  input wire logic nvm_magic_wake_en_i,
  input wire logic [23:0] nvm_ind_cfg_i,
  input wire logic rx_pkt_valid_i,
  input wire logic rx_addr_pass_i,
  input wire logic rx_magic_i,
  input wire logic [7:0] rx_filter_hit_i,
  output logic rx_deliver_o,
  input wire logic phy_link_up_i,
  input wire logic [1:0] phy_speed_i,
  input wire logic phy_full_duplex_i,
  input wire logic phy_activity_i,
  input wire logic phy_collision_i,
  input wire logic phy_src_tx_throttled_i,
  input wire logic legacy_mode_i,
  output logic narrow_phy_link_en_o,
  output logic gigabit_phy_link_en_o,
  output logic link_valid_o,
  output logic power_event_flag_o,
  output logic wake_req_o,
  output logic low_power_o,
  output logic [2:0] indicator_o
);
  lwle_pkg::lwle_state_t st;
  lwle_pkg::lwle_state_t next_st;
  logic link_ok;
  logic rx_blocked;
  logic magic_hit;
  logic [lwle_pkg::NUM_FILT-1:0] filt_hits;
  logic filt_hit;
  logic lnk_evt;
  logic perr_evt;
  logic cpl_bad;
  logic pm_wr;
  logic wake_clr;
  logic [23:0] half_period;

  // set wins over clear for every sticky flag
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  function automatic logic ind_source(input logic [3:0] mode, input logic up,
                                      input logic [1:0] spd, input logic [lwle_pkg::PS_W-1:0] ps);
    ind_source = 1'b0;
    case (mode)
      lwle_pkg::SRC_LINK_100_1000: ind_source = up & (spd != lwle_pkg::SPD_10);
      lwle_pkg::SRC_LINK_10_1000: ind_source = up & (spd != lwle_pkg::SPD_100);
      lwle_pkg::SRC_LINK_UP: ind_source = up;
      lwle_pkg::SRC_ACTIVITY: ind_source = up & ps[lwle_pkg::PS_ACT];
      lwle_pkg::SRC_LINK_IDLE: ind_source = up & ~ps[lwle_pkg::PS_ACT];
      lwle_pkg::SRC_LINK_10: ind_source = up & (spd == lwle_pkg::SPD_10);
      lwle_pkg::SRC_LINK_100: ind_source = up & (spd == lwle_pkg::SPD_100);
      lwle_pkg::SRC_LINK_1000: ind_source = up & (spd == lwle_pkg::SPD_1000);
      lwle_pkg::SRC_FULL_DUPLEX: ind_source = up & ps[lwle_pkg::PS_DUPLEX];
      lwle_pkg::SRC_COLLISION: ind_source = ps[lwle_pkg::PS_COL];
      lwle_pkg::SRC_TX_THROTTLED: ind_source = ps[lwle_pkg::PS_PAUSE];
      lwle_pkg::SRC_CONST_ON: ind_source = 1'b1;
      lwle_pkg::SRC_CONST_OFF: ind_source = 1'b0;
      default: ind_source = 1'b0;
    endcase
  endfunction : ind_source

  // host bus gating, handshake outputs are combinational
  assign hb_req_accept_o = hb_req_valid_i & ~hb_parity_err_i &
                           ((st.pstate == lwle_pkg::PSTATE_D0) | hb_req_is_cfg_i);
  assign hb_req_drop_o = hb_req_valid_i & ~hb_req_accept_o;
  assign cpl_accept_o = cpl_valid_i & ~hb_parity_err_i & (cpl_status_i == lwle_pkg::CPL_SUCCESS);
  // dropped completions are final: no retry request exists in this block
  assign cpl_drop_o = cpl_valid_i & ~cpl_accept_o;
  assign perr_evt = hb_parity_err_i & (hb_req_valid_i | cpl_valid_i);
  assign cpl_bad = cpl_valid_i & ~hb_parity_err_i & (cpl_status_i != lwle_pkg::CPL_SUCCESS);

  // link mode checks on synchronised phy status
  assign link_ok = st.phy_s2[lwle_pkg::PS_LINK] &
                   ~(st.phy_s2[lwle_pkg::PS_SPD +: 2] == 2'h3) &
                   ~((st.phy_s2[lwle_pkg::PS_SPD +: 2] == lwle_pkg::SPD_1000) &
                     (~st.phy_s2[lwle_pkg::PS_DUPLEX] | st.phy_s2[lwle_pkg::PS_LEGACY]));
  assign narrow_phy_link_en_o = 1'b1;
  assign gigabit_phy_link_en_o = ~st.phy_s2[lwle_pkg::PS_LEGACY];
  assign link_valid_o = link_ok;

  // wake event detection
  assign rx_blocked = st.wus_magic | (|st.wus_filt);
  assign magic_hit = rx_pkt_valid_i & st.magic_en & rx_magic_i & ~rx_blocked;
  assign filt_hits = rx_filter_hit_i & st.filt_sel &
                     {lwle_pkg::NUM_FILT{rx_pkt_valid_i & rx_addr_pass_i & ~rx_blocked}};
  assign filt_hit = |filt_hits;
  assign lnk_evt = st.lnk_wake_en & ~st.wus_link &
                   (st.phy_s2[lwle_pkg::PS_LINK] != st.link_prev);

  // software clear strobes for the wake request
  assign pm_wr = reg_we_i & (reg_addr_i == lwle_pkg::ADDR_POWER_CTL_STATUS_REG);
  assign wake_clr = pm_wr & (reg_wdata_i[lwle_pkg::PM_FLAG] | ~reg_wdata_i[lwle_pkg::PM_EN]);

  // one rate for all indicators, chosen by a single bit
  assign half_period = st.blink_fast ? BLINK_FAST_CYC : BLINK_SLOW_CYC;

  always_comb begin
    next_st = st;
    // two flop synchroniser for phy pins and the mode strap
    next_st.phy_s1 = {legacy_mode_i, phy_src_tx_throttled_i, phy_collision_i, phy_activity_i,
                      phy_full_duplex_i, phy_speed_i, phy_link_up_i};
    next_st.phy_s2 = st.phy_s1;
    next_st.link_prev = st.phy_s2[lwle_pkg::PS_LINK];

    // software writes
    if (reg_we_i) begin
      unique case (reg_addr_i)
        lwle_pkg::ADDR_CFG: begin
          next_st.perr_report_en = reg_wdata_i[lwle_pkg::CFG_PERR_EN];
          next_st.serr_en = reg_wdata_i[lwle_pkg::CFG_SERR_EN];
        end
        lwle_pkg::ADDR_POWER_CTL_STATUS_REG: begin
          next_st.power_event_enable = reg_wdata_i[lwle_pkg::PM_EN];
          // only D0 and D3 exist; other codes leave the state alone
          if (reg_wdata_i[1:0] == lwle_pkg::PSTATE_D3) begin
            next_st.pstate = lwle_pkg::PSTATE_D3;
          end else if (reg_wdata_i[1:0] == lwle_pkg::PSTATE_D0) begin
            next_st.pstate = lwle_pkg::PSTATE_D0;
          end
        end
        lwle_pkg::ADDR_WUC: next_st.magic_en = reg_wdata_i[lwle_pkg::WUC_MAGIC];
        lwle_pkg::ADDR_WAKE_FILTER_CONTROL_REG: begin
          next_st.lnk_wake_en = reg_wdata_i[lwle_pkg::WAKE_FILTER_CONTROL_REG_LNK];
          next_st.filt_sel = reg_wdata_i[lwle_pkg::WAKE_FILTER_CONTROL_REG_FILT_LSB +: lwle_pkg::NUM_FILT];
        end
        lwle_pkg::ADDR_IND: begin
          next_st.ind_cfg = reg_wdata_i[lwle_pkg::NUM_IND*lwle_pkg::IND_W-1:0];
          next_st.blink_fast = reg_wdata_i[lwle_pkg::IND_BLINK_FAST];
        end
        default: ;
      endcase
    end

    // nvm load comes after software so a fresh nvm read wins
    if (nvm_load_i) begin
      next_st.magic_en = nvm_magic_wake_en_i;
      next_st.ind_cfg = nvm_ind_cfg_i;
    end

    // error flags
    next_st.parity_flag = sticky(st.parity_flag, perr_evt, reg_we_i &
                                 (reg_addr_i == lwle_pkg::ADDR_CFG) &
                                 reg_wdata_i[lwle_pkg::CFG_PERR_FLAG]);
    next_st.serr_flag = sticky(st.serr_flag, cpl_bad, reg_we_i &
                               (reg_addr_i == lwle_pkg::ADDR_CFG) &
                               reg_wdata_i[lwle_pkg::CFG_SERR_FLAG]);
    next_st.sys_err = (perr_evt & st.perr_report_en) | (cpl_bad & st.serr_en);

    // wake status, each matching filter keeps its own bit
    for (int f = 0; f < lwle_pkg::NUM_FILT; f++) begin
      next_st.wus_filt[f] = sticky(st.wus_filt[f], filt_hits[f], reg_we_i &
                                   (reg_addr_i == lwle_pkg::ADDR_WUS) &
                                   reg_wdata_i[lwle_pkg::WUS_FILT_LSB + f]);
    end
    next_st.wus_magic = sticky(st.wus_magic, magic_hit, reg_we_i &
                               (reg_addr_i == lwle_pkg::ADDR_WUS) &
                               reg_wdata_i[lwle_pkg::WUS_MAGIC]);
    next_st.wus_link = sticky(st.wus_link, lnk_evt, reg_we_i &
                              (reg_addr_i == lwle_pkg::ADDR_WUS) &
                              reg_wdata_i[lwle_pkg::WUS_LNK]);
    next_st.pme_flag = sticky(st.pme_flag, magic_hit | filt_hit | lnk_evt,
                              pm_wr & reg_wdata_i[lwle_pkg::PM_FLAG]);

    // request trails the flag by one cycle so the flag is always seen first
    next_st.wake_pend = magic_hit | lnk_evt | (filt_hit & st.power_event_enable);
    next_st.wake_req = sticky(st.wake_req, st.wake_pend, wake_clr);
    next_st.rx_deliver = rx_pkt_valid_i & ~magic_hit & ~filt_hit;

    // shared blink divider
    // free running: indicators never drift apart in phase
    if (st.blink_cnt >= half_period - 24'h000001) begin
      next_st.blink_cnt = '0;
      next_st.blink_phase = ~st.blink_phase;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 24'h000001;
    end

    // invert first, so blink gates the polarity-corrected source
    for (int i = 0; i < lwle_pkg::NUM_IND; i++) begin
      next_st.ind_out[i] = ind_source(st.ind_cfg[i*lwle_pkg::IND_W +: 4], link_ok,
                                      st.phy_s2[lwle_pkg::PS_SPD +: 2], st.phy_s2) ^
                           st.ind_cfg[i*lwle_pkg::IND_W + lwle_pkg::IND_INV];
      if (st.ind_cfg[i*lwle_pkg::IND_W + lwle_pkg::IND_BLINK]) begin
        next_st.ind_out[i] = next_st.ind_out[i] & st.blink_phase;
      end
    end

    // registered read data, unmapped offsets read zero
    next_st.rdata = '0;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        lwle_pkg::ADDR_CFG: begin
          next_st.rdata[lwle_pkg::CFG_PERR_EN] = st.perr_report_en;
          next_st.rdata[lwle_pkg::CFG_SERR_EN] = st.serr_en;
          next_st.rdata[lwle_pkg::CFG_PERR_FLAG] = st.parity_flag;
          next_st.rdata[lwle_pkg::CFG_SERR_FLAG] = st.serr_flag;
        end
        lwle_pkg::ADDR_POWER_CTL_STATUS_REG: begin
          next_st.rdata[1:0] = st.pstate;
          next_st.rdata[lwle_pkg::PM_EN] = st.power_event_enable;
          next_st.rdata[lwle_pkg::PM_FLAG] = st.pme_flag;
        end
        lwle_pkg::ADDR_WUC: next_st.rdata[lwle_pkg::WUC_MAGIC] = st.magic_en;
        lwle_pkg::ADDR_WAKE_FILTER_CONTROL_REG: begin
          next_st.rdata[lwle_pkg::WAKE_FILTER_CONTROL_REG_LNK] = st.lnk_wake_en;
          next_st.rdata[lwle_pkg::WAKE_FILTER_CONTROL_REG_FILT_LSB +: lwle_pkg::NUM_FILT] = st.filt_sel;
        end
        lwle_pkg::ADDR_WUS: begin
          next_st.rdata[lwle_pkg::WUS_LNK] = st.wus_link;
          next_st.rdata[lwle_pkg::WUS_MAGIC] = st.wus_magic;
          next_st.rdata[lwle_pkg::WUS_FILT_LSB +: lwle_pkg::NUM_FILT] = st.wus_filt;
        end
        lwle_pkg::ADDR_IND: begin
          next_st.rdata[lwle_pkg::NUM_IND*lwle_pkg::IND_W-1:0] = st.ind_cfg;
          next_st.rdata[lwle_pkg::IND_BLINK_FAST] = st.blink_fast;
        end
        lwle_pkg::ADDR_LINK: begin
          next_st.rdata[lwle_pkg::PS_W-1:0] = st.phy_s2;
          next_st.rdata[lwle_pkg::PS_W] = link_ok;
        end
        default: ;
      endcase
    end
  end

  // sync reset; indicator defaults return with it until nvm reloads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ind_cfg <= lwle_pkg::IND_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign system_error_o = st.sys_err;
  assign rx_deliver_o = st.rx_deliver;
  assign power_event_flag_o = st.pme_flag;
  assign wake_req_o = st.wake_req;
  assign low_power_o = (st.pstate == lwle_pkg::PSTATE_D3);
  assign indicator_o = st.ind_out;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_PERR_DROP: assert property (hb_req_valid_i && hb_parity_err_i |-> !hb_req_accept_o ##1
    st.parity_flag) else $error("parity cycle accepted or flag not set");

  AST_PERR_SERR: assert property (perr_evt && st.perr_report_en && !reg_we_i |=>
    system_error_o) else $error("parity error without system error");

  AST_CPL_BAD: assert property (cpl_bad |-> cpl_drop_o && !cpl_accept_o ##1
    st.serr_flag) else $error("bad completion not dropped or flag missing");

  AST_GIG_HALF: assert property (st.phy_s2[lwle_pkg::PS_SPD +: 2] == lwle_pkg::SPD_1000 &&
    !st.phy_s2[lwle_pkg::PS_DUPLEX] |-> !link_valid_o)
    else $error("half duplex gigabit link reported valid");

  AST_D3_REFUSE: assert property (hb_req_valid_i && !hb_req_is_cfg_i && low_power_o |->
    !hb_req_accept_o) else $error("request accepted outside D0");

  AST_WAKE_ORDER: assert property ($rose(wake_req_o) |-> $past(st.pme_flag) ||
    $past(st.wake_pend)) else $error("wake request without preceding event");

  AST_WAKE_LATE: assert property (st.wake_pend |=> wake_req_o)
    else $error("pending wake not raised");

  AST_DELIVER: assert property (rx_pkt_valid_i && !magic_hit && !filt_hit |=>
    rx_deliver_o) else $error("ordinary packet not delivered");

  // nvm wins a same-cycle software write, so the loaded values must show
  AST_NVM_LOAD: assert property (nvm_load_i |=>
    st.magic_en == $past(nvm_magic_wake_en_i) && st.ind_cfg == $past(nvm_ind_cfg_i))
    else $error("nvm word not loaded");

  AST_MAGIC: assert property (magic_hit && !reg_we_i |=> st.wus_magic && st.pme_flag &&
    !rx_deliver_o ##1 wake_req_o) else $error("magic packet wake sequence wrong");

  AST_FILT_NOEN: assert property (filt_hit && !magic_hit && !lnk_evt && !st.power_event_enable |=>
    !st.wake_pend) else $error("filtered wake without power event enable");

  AST_FILT_ALL: assert property (filt_hit |=>
    (st.wus_filt & $past(filt_hits)) == $past(filt_hits))
    else $error("matching filter status bit missing");

  AST_LNK_EVT: assert property (lnk_evt |=> st.wus_link && st.pme_flag ##1 wake_req_o)
    else $error("link change wake sequence wrong");

  AST_WAKE_HOLD: assert property (wake_req_o && !wake_clr |=> wake_req_o)
    else $error("wake request dropped without clear");

  AST_WAKE_CLEAR: assert property (wake_req_o && wake_clr && !st.wake_pend |=>
    !wake_req_o) else $error("wake request not cleared");

  AST_BLOCKED: assert property (st.wus_magic && rx_pkt_valid_i |-> !magic_hit && !filt_hit)
    else $error("wake packet taken while status pending");

  AST_LNK_IGN: assert property (st.wus_link |-> !lnk_evt)
    else $error("link change taken while status pending");

  AST_D3_ENTER: assert property (pm_wr && reg_wdata_i[1:0] == lwle_pkg::PSTATE_D3 |=>
    low_power_o) else $error("D3 write not honoured");

  AST_CONST_OFF: assert property (st.ind_cfg[3:0] == lwle_pkg::SRC_CONST_OFF &&
    !st.ind_cfg[lwle_pkg::IND_INV] |=> !indicator_o[0]) else $error("constant off lit");

  // main scenarios
  COV_MAGIC: cover property (magic_hit ##2 wake_req_o);
  COV_D3: cover property (pm_wr ##1 low_power_o);
  COV_FILT: cover property (filt_hit && st.power_event_enable ##2 wake_req_o);
  COV_LINK: cover property (lnk_evt ##1 st.wus_link);
  COV_PERR: cover property (perr_evt && st.perr_report_en ##1 system_error_o);
endmodule : lwle_top
`default_nettype wire

/* File: lwle_host_model.sv */
// host chipset model: issues single requests and completions, counts system errors
`timescale 1ns/1ps
`default_nettype none
module lwle_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire logic cfg_i,
  input wire logic perr_i,
  input wire logic cpl_i,
  input wire logic [2:0] status_i,
  input wire logic system_error_i,
  output logic hb_req_valid_o,
  output logic hb_req_is_cfg_o,
  output logic hb_parity_err_o,
  output logic cpl_valid_o,
  output logic [2:0] cpl_status_o,
  output logic [7:0] serr_cnt_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {hb_req_valid_o, hb_req_is_cfg_o, hb_parity_err_o, cpl_valid_o} <= 4'h0;
      cpl_status_o <= 3'h0;
      serr_cnt_o <= 8'h00;
    end else begin
      // one cycle per unit; a refused unit is never sent again
      hb_req_valid_o <= issue_i & ~cpl_i;
      cpl_valid_o <= issue_i & cpl_i;
      hb_parity_err_o <= issue_i & perr_i;
      // idle qualifiers wander so a design reading them unqualified shows up
      hb_req_is_cfg_o <= issue_i ? cfg_i : ~hb_req_is_cfg_o;
      cpl_status_o <= issue_i ? status_i : ~cpl_status_o;
      if (system_error_i) serr_cnt_o <= serr_cnt_o + 8'h01;
    end
  end
endmodule : lwle_host_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench of the lan wake, indicator and error sideband
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic clk_i, rst_i, reg_we_i, reg_re_i, hb_req_valid_i, hb_req_is_cfg_i, hb_parity_err_i;
  logic [7:0] reg_addr_i, rx_filter_hit_i, serr_cnt;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic hb_req_accept_o, hb_req_drop_o, cpl_valid_i, cpl_accept_o, cpl_drop_o, system_error_o;
  logic [2:0] cpl_status_i, indicator_o, h_st;
  logic nvm_load_i, nvm_magic_wake_en_i, rx_pkt_valid_i, rx_addr_pass_i, rx_magic_i, rx_deliver_o;
  logic [23:0] nvm_ind_cfg_i;
  logic phy_link_up_i, phy_full_duplex_i, phy_activity_i, phy_collision_i, phy_src_tx_throttled_i;
  logic legacy_mode_i, narrow_phy_link_en_o, gigabit_phy_link_en_o, link_valid_o;
  logic power_event_flag_o, wake_req_o, low_power_o, h_go, h_cfg, h_perr, h_cpl, prv;
  logic [1:0] phy_speed_i;
  int error_cnt = 0, cmp_count = 0, cyc_cnt = 0, tgl, miss;
  logic [31:0] ind_tab [5] = '{32'h00250100, 32'h00070605, 32'h00090803, 32'h000f0a04, 32'h000e020a};
  logic [2:0] ind_exp [5] = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h6};

  // small half periods keep the blink test short
  lwle_top #(.BLINK_SLOW_CYC(24'h8), .BLINK_FAST_CYC(24'h4)) i_dut (.*);
  lwle_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .issue_i(h_go), .cfg_i(h_cfg),
    .perr_i(h_perr), .cpl_i(h_cpl), .status_i(h_st), .system_error_i(system_error_o),
    .hb_req_valid_o(hb_req_valid_i), .hb_req_is_cfg_o(hb_req_is_cfg_i),
    .hb_parity_err_o(hb_parity_err_i), .cpl_valid_o(cpl_valid_i), .cpl_status_o(cpl_status_i),
    .serr_cnt_o(serr_cnt));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask : rd
  task automatic host(input logic c, p, cp, input logic [2:0] s, input logic acc, drp);
    @(posedge clk_i);
    {h_go, h_cfg, h_perr, h_cpl, h_st} <= {1'b1, c, p, cp, s};
    @(posedge clk_i);
    h_go <= 1'b0;
    #1 `CHK(cp ? {cpl_accept_o, cpl_drop_o} : {hb_req_accept_o, hb_req_drop_o}, {acc, drp})
  endtask : host
  task automatic pkt(input logic ap, mg, input logic [7:0] h);
    @(posedge clk_i);
    {rx_pkt_valid_i, rx_addr_pass_i, rx_magic_i, rx_filter_hit_i} <= {1'b1, ap, mg, h};
    @(posedge clk_i);
    rx_pkt_valid_i <= 1'b0;
    #1;
  endtask : pkt

  initial begin
    {rst_i, reg_we_i, reg_re_i, h_go, h_cfg, h_perr, h_cpl, nvm_load_i} = 8'h80;
    {reg_addr_i, reg_wdata_i, h_st, rx_filter_hit_i, nvm_ind_cfg_i} = '0;
    {nvm_magic_wake_en_i, rx_pkt_valid_i, rx_addr_pass_i, rx_magic_i, legacy_mode_i} = 5'h0;
    {phy_link_up_i, phy_speed_i, phy_full_duplex_i, phy_activity_i} = 5'h0;
    {phy_collision_i, phy_src_tx_throttled_i} = 2'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h0);
    rd(lwle_pkg::ADDR_IND, 32'h302);
    rd(8'h1c, 32'h0);
    $display("reset values done");
    wr(lwle_pkg::ADDR_CFG, 32'h3);
    host(1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 1'b1);
    host(1'b0, 1'b0, 1'b1, 3'h2, 1'b0, 1'b1);
    host(1'b0, 1'b0, 1'b1, 3'h0, 1'b1, 1'b0);
    rd(lwle_pkg::ADDR_CFG, 32'h303);
    `CHK(serr_cnt, 8'h2)
    wr(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h3);
    `CHK(low_power_o, 1'b1)
    host(1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1);
    host(1'b1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0);
    $display("host errors and power state done");
    @(posedge clk_i);
    {nvm_load_i, nvm_magic_wake_en_i, nvm_ind_cfg_i} <= {2'h3, 24'h0f0f0e};
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    rd(lwle_pkg::ADDR_WUC, 32'h1);
    rd(lwle_pkg::ADDR_IND, 32'h0f0f0e);
    `CHK(indicator_o, 3'h1)
    pkt(1'b1, 1'b1, 8'h0);
    `CHK({rx_deliver_o, power_event_flag_o, wake_req_o}, 3'h2)
    cyc(1);
    `CHK(wake_req_o, 1'b1)
    rd(lwle_pkg::ADDR_WUS, 32'h2);
    wr(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h8003);
    cyc(1);
    `CHK({power_event_flag_o, wake_req_o}, 2'h0)
    pkt(1'b1, 1'b1, 8'h0);
    cyc(2);
    `CHK(power_event_flag_o, 1'b0)
    wr(lwle_pkg::ADDR_WUS, 32'h2);
    wr(lwle_pkg::ADDR_WUC, 32'h0);
    pkt(1'b1, 1'b1, 8'h0);
    cyc(2);
    `CHK(power_event_flag_o, 1'b0)
    $display("magic wake done");
    wr(lwle_pkg::ADDR_WAKE_FILTER_CONTROL_REG, 32'h6);
    wr(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h103);
    pkt(1'b0, 1'b0, 8'h3);
    cyc(2);
    `CHK(power_event_flag_o, 1'b0)
    pkt(1'b1, 1'b0, 8'h7);
    cyc(1);
    `CHK({power_event_flag_o, wake_req_o}, 2'h3)
    rd(lwle_pkg::ADDR_WUS, 32'hc);
    wr(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h3);
    cyc(1);
    `CHK(wake_req_o, 1'b0)
    rd(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h8003);
    wr(lwle_pkg::ADDR_POWER_CTL_STATUS_REG, 32'h8000);
    wr(lwle_pkg::ADDR_WUS, 32'hc);
    $display("filtered wake done");
    wr(lwle_pkg::ADDR_WAKE_FILTER_CONTROL_REG, 32'h1);
    {phy_link_up_i, phy_speed_i, phy_full_duplex_i} <= 4'hd;
    cyc(6);
    `CHK({power_event_flag_o, wake_req_o, link_valid_o}, 3'h7)
    rd(lwle_pkg::ADDR_WUS, 32'h1);
    phy_full_duplex_i <= 1'b0;
    cyc(4);
    `CHK(link_valid_o, 1'b0)
    {phy_full_duplex_i, legacy_mode_i} <= 2'h3;
    cyc(4);
    `CHK({narrow_phy_link_en_o, gigabit_phy_link_en_o}, 2'h2)
    legacy_mode_i <= 1'b0;
    $display("link wake done");
    for (int i = 0; i < 5; i++) begin
      wr(lwle_pkg::ADDR_IND, ind_tab[i]);
      cyc(2);
      `CHK(indicator_o, ind_exp[i])
    end
    for (int r = 0; r < 2; r++) begin
      wr(lwle_pkg::ADDR_IND, r ? 32'h01008e8e : 32'h00008e8e);
      {tgl, miss} = '0;
      cyc(2);
      prv = indicator_o[0];
      for (int k = 0; k < 40; k++) begin
        cyc(1);
        miss += int'(indicator_o[0] !== indicator_o[1]);
        tgl += int'(indicator_o[0] !== prv);
        prv = indicator_o[0];
      end
      `CHK(r ? (tgl >= 7 && tgl <= 11) : (tgl >= 3 && tgl <= 6), 1'b1)
      `CHK(miss, 0)
    end
    $display("indicators done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
